/* hdl/underload_defines.svh */
// Timing, range, default and code constants for the underload and restart supervisor
`ifndef UNDERLOAD_DEFINES_SVH
`define UNDERLOAD_DEFINES_SVH

// ==========================================
// Clock and time base
`define SYS_CLK_HZ 20000000
`define TICK_MS 100
`define TICK_CYCLES (`SYS_CLK_HZ / 1000 * `TICK_MS)

// ==========================================
// Protection modes (2-bit setting)
`define UL_MODE_OFF 2'h0
`define UL_MODE_WARN 2'h1
`define UL_MODE_FAULT 2'h2

// ==========================================
// Frequencies in 0.1 Hz, torques in 0.1 %, times in 0.1 s
`define UL_MIN_FREQ 16'h0032
`define FW_LOAD_MIN 16'h00c8
`define FW_LOAD_MAX 16'h05dc
`define ZERO_LOAD_MIN 16'h0064
`define ZERO_LOAD_MAX 16'h05dc
`define UL_TIME_MIN 16'h0014
`define UL_TIME_MAX 16'h1770
`define FW_LOAD_DEFAULT 16'h01f4
`define ZERO_LOAD_DEFAULT 16'h0064
`define NOM_CURRENT_DEFAULT 16'h0064

// ==========================================
// Restart conditions: reference in 0.01 mA, heatsink in degrees C
`define REF_OK_MIN 16'h0190
`define TEMP_OK_MIN 16'shfff6
`define TEMP_OK_MAX 16'sh004b

// ==========================================
// Display indication codes
`define IND_NONE 4'h0
`define IND_UNDERLOAD 4'h1

`endif

/* hdl/underload_pkg.sv */
// Types shared by the underload and restart supervisor
package underload_pkg;

    // ==========================================
    // Fault causes, also used as per-cause restart enables
    typedef struct packed {
        logic uv;
        logic ov;
        logic oc;
        logic refc;
        logic temp;
    } fault_kind_t;

    // ==========================================
    // Live estimates from the drive control core
    typedef struct packed {
        logic running;
        logic [15:0] out_freq;
        logic signed [15:0] torque_raw;
        logic [15:0] fw_freq;
    } drive_meas_t;

    // ==========================================
    // Conditions that gate a restart
    typedef struct packed {
        logic dc_ok;
        logic [15:0] ref_current;
        logic signed [15:0] heatsink_temp;
    } restart_cond_t;

    typedef enum logic [2:0] {
        RS_IDLE = 3'b001,
        RS_WAIT = 3'b010,
        RS_LOCK = 3'b100
    } restart_state_t;

endpackage

/* hdl/underload_restart.sv */
// Motor underload supervision and automatic fault restart
// Operation
// R1: Mode selects off, warning or fault
// R2: Underload fault stops motor, enters fault
// R3: Mode off clears underload counter
// R4: Below 5 Hz counter holds, no counting
// R5: Threshold squared curve up to field weakening
// R6: Field weakening load limited 20.0 to 150 percent
// R7: Zero frequency load limited 10.0 to 150
// R8: Nominal current change restores both load defaults
// R9: Torque scaled by nominal and rated currents
// R10: Counter counts up in underload, else down
// R11: Counter above time limit triggers mode action
// R12: Stopped drive resets underload counter
// R13: Limited restarts in trial time, enabled causes
// R14: Trial time starts at first restart
// R15: Trial expiry within limit clears count, timer
// R16: Next fault after clearing counts afresh
// R17: Start mode selects ramp or flying start
// R18: Voltage trips restart once DC-link normal
// R19: Overcurrent restarts only when enabled
// R20: Reference fault waits for above 4 mA
// R21: Temperature fault waits for -10 to 75 C
// R22: Underload means running with torque below curve
// R23: Fault beyond restart limit stays latched
`include "underload_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module underload_restart
    import underload_pkg::*;
#(
    parameter int TICK_CYCLES = `TICK_CYCLES,
    parameter int TRY_W = 4
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire drive_meas_t meas,
    input wire logic [1:0] ul_mode,
    input wire logic [15:0] ul_time,
    input wire logic fw_load_wr,
    input wire logic [15:0] fw_load_in,
    input wire logic zero_load_wr,
    input wire logic [15:0] zero_load_in,
    input wire logic nom_current_wr,
    input wire logic [15:0] nom_current_in,
    input wire logic [15:0] drive_rated_current,
    input wire logic fault_valid,
    input wire fault_kind_t fault_kind,
    input wire fault_kind_t restart_en,
    input wire restart_cond_t cond,
    input wire logic [TRY_W-1:0] max_tries,
    input wire logic [15:0] trial_time,
    input wire logic start_mode,
    input wire logic fault_reset,
    output logic [15:0] fw_load,
    output logic [15:0] zero_load,
    output logic [15:0] motor_nom_current,
    output logic [15:0] ul_count,
    output logic ul_warning,
    output logic [3:0] ul_indication,
    output logic motor_stop,
    output logic fault_active,
    output logic restart_pulse,
    output logic restart_flying,
    output logic [TRY_W-1:0] tries_used
);

    // ==========================================
    // Helpers
    function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo,
                                          input logic [15:0] hi);
        if (v < lo) return lo;
        if (v > hi) return hi;
        return v;
    endfunction

    function automatic logic [15:0] min_torque(input logic [15:0] f, input logic [15:0] fwp,
                                               input logic [15:0] fw, input logic [15:0] z);
        logic signed [63:0] d;
        logic signed [63:0] q;
        logic [31:0] sq;
        logic [31:0] den;
        d = $signed(64'(fw)) - $signed(64'(z));
        sq = 32'(f) * 32'(f);
        den = 32'(fwp) * 32'(fwp);
        if (fwp == 16'h0000 || f >= fwp) return fw;
        q = (d * $signed(64'(sq))) / $signed(64'(den));
        return 16'($signed(64'(z)) + q);
    endfunction

    function automatic logic restart_ok(input fault_kind_t k, input restart_cond_t c);
        logic ok;
        ok = 1'b1;
        if (k.uv || k.ov) ok = ok && c.dc_ok;
        if (k.refc) ok = ok && (c.ref_current > `REF_OK_MIN);
        if (k.temp) begin
            ok = ok && (c.heatsink_temp >= `TEMP_OK_MIN) && (c.heatsink_temp <= `TEMP_OK_MAX);
        end
        return ok;
    endfunction

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // ==========================================
    // Time base: one 100 ms enable pulse
    logic [31:0] tick_cnt;
    logic tick;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt <= 32'h0;
            tick <= 1'b0;
        end else if (tick_cnt == 32'(TICK_CYCLES - 1)) begin
            tick_cnt <= 32'h0;
            tick <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 32'h1;
            tick <= 1'b0;
        end
    end

    // ==========================================
    // Load settings; a new nominal current restores both load defaults
    logic nom_change;
    assign nom_change = nom_current_wr && (nom_current_in != motor_nom_current);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            motor_nom_current <= `NOM_CURRENT_DEFAULT;
        end else if (nom_current_wr) begin
            motor_nom_current <= nom_current_in;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            fw_load <= `FW_LOAD_DEFAULT;
            zero_load <= `ZERO_LOAD_DEFAULT;
        end else if (nom_change) begin
            fw_load <= `FW_LOAD_DEFAULT; // R8
            zero_load <= `ZERO_LOAD_DEFAULT; // R8
        end else begin
            if (fw_load_wr) fw_load <= clamp(fw_load_in, `FW_LOAD_MIN, `FW_LOAD_MAX); // R6
            if (zero_load_wr) begin
                zero_load <= clamp(zero_load_in, `ZERO_LOAD_MIN, `ZERO_LOAD_MAX); // R7
            end
        end
    end

    // ==========================================
    // Underload detection
    // Raw torque is relative to drive rated current; rescale to motor rated torque
    logic signed [47:0] torque_pct;
    logic [15:0] threshold;
    logic underload;

    always_comb begin
        torque_pct = 48'sh0;
        if (motor_nom_current != 16'h0000) begin
            torque_pct = ($signed(48'(meas.torque_raw)) * $signed(48'(drive_rated_current)))
                         / $signed(48'(motor_nom_current)); // R9
        end
    end

    assign threshold = min_torque(meas.out_freq, meas.fw_freq, fw_load, zero_load); // R5
    assign underload = meas.running && (torque_pct < $signed(48'(threshold))); // R22

    // ==========================================
    // Underload time counter in 0.1 s steps
    logic ul_over;
    logic ul_trip;
    assign ul_over = ul_count > clamp(ul_time, `UL_TIME_MIN, `UL_TIME_MAX); // R11

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ul_count <= 16'h0;
        end else if (ul_mode == `UL_MODE_OFF) begin
            ul_count <= 16'h0; // R3
        end else if (!meas.running) begin
            ul_count <= 16'h0; // R12
        end else if (tick && meas.out_freq >= `UL_MIN_FREQ) begin // R4
            if (underload && ul_count != 16'hffff) begin
                ul_count <= ul_count + 16'h1; // R10
            end else if (!underload && ul_count != 16'h0) begin
                ul_count <= ul_count - 16'h1; // R10
            end
        end
    end

    // Trip fires once per latched fault so a held overrun does not restart the sequence
    assign ul_trip = (ul_mode == `UL_MODE_FAULT) && ul_over && !motor_stop; // R2

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ul_warning <= 1'b0;
            ul_indication <= `IND_NONE;
        end else begin
            ul_warning <= (ul_mode == `UL_MODE_WARN) && ul_over; // R1
            ul_indication <= (ul_mode != `UL_MODE_OFF && ul_over) ? `IND_UNDERLOAD
                                                                 : `IND_NONE; // R1
        end
    end

    // ==========================================
    // Automatic restart sequencer
    restart_state_t state;
    fault_kind_t pending;
    logic fault_ev;
    logic go;
    logic [15:0] trial_cnt;
    logic trial_active;
    logic trial_done;

    assign fault_ev = fault_valid || ul_trip;
    assign go = (state == RS_WAIT) && restart_ok(pending, cond); // R18 R20 R21
    assign trial_done = tick && trial_active && (trial_cnt >= trial_time) && (state != RS_LOCK);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= RS_IDLE;
            pending <= '0;
        end else begin
            unique case (state)
                RS_IDLE: begin
                    if (fault_ev) begin
                        // Underload trips carry no restartable cause
                        pending <= ul_trip ? '0 : (fault_kind & restart_en); // R19
                        if (!ul_trip && |(fault_kind & restart_en) && tries_used < max_tries) begin
                            state <= RS_WAIT; // R13
                        end else begin
                            state <= RS_LOCK; // R23
                        end
                    end
                end
                RS_WAIT: begin
                    if (go) state <= RS_IDLE;
                end
                RS_LOCK: begin
                    if (fault_reset) state <= RS_IDLE; // R23
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            restart_pulse <= 1'b0;
            restart_flying <= 1'b0;
        end else begin
            restart_pulse <= go;
            if (go) restart_flying <= start_mode; // R17
        end
    end

    // Trial window opens on the first restart, not on the fault itself
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tries_used <= '0;
            trial_active <= 1'b0;
            trial_cnt <= 16'h0;
        end else if (go) begin
            tries_used <= tries_used + TRY_W'(1); // R13
            if (!trial_active) begin
                trial_active <= 1'b1; // R14
                trial_cnt <= 16'h0; // R14
            end
        end else if (trial_done) begin
            tries_used <= '0; // R15 R16
            trial_active <= 1'b0; // R15
            trial_cnt <= 16'h0; // R15
        end else if (tick && trial_active) begin
            trial_cnt <= trial_cnt + 16'h1;
        end
    end

    // ==========================================
    // Fault state; a new trip wins over a reset in the same cycle
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            motor_stop <= 1'b0;
        end else if (ul_trip) begin
            motor_stop <= 1'b1; // R2
        end else if (fault_reset || go) begin
            motor_stop <= 1'b0;
        end
    end

    assign fault_active = motor_stop || (state != RS_IDLE); // R2

    // ==========================================
    // Checks
    ul_off_clear_a: assert property ((ul_mode == `UL_MODE_OFF) |=> ul_count == 16'h0) // R3
        else $error("underload counter not cleared in off mode");
    ul_stop_clear_a: assert property (!meas.running |=> ul_count == 16'h0) // R12
        else $error("underload counter not cleared while stopped");
    ul_low_hold_a: assert property (meas.running && ul_mode != `UL_MODE_OFF && // R4
        meas.out_freq < `UL_MIN_FREQ |=> $stable(ul_count))
        else $error("underload counter moved below minimum frequency");
    ul_count_up_a: assert property (tick && underload && ul_mode != `UL_MODE_OFF && // R10
        meas.out_freq >= `UL_MIN_FREQ && ul_count < 16'h00ff |=> ul_count == $past(ul_count) + 16'h1)
        else $error("underload counter did not count up");
    ul_trip_stop_a: assert property (ul_trip |-> ul_over ##1 motor_stop && fault_active) // R2
        else $error("underload trip did not stop the motor");
    // A stop latched in an earlier fault mode may still stand, so only a new stop is an error
    ul_warn_code_a: assert property (ul_mode == `UL_MODE_WARN && ul_over // R1
        |=> ul_warning && ul_indication == `IND_UNDERLOAD && !$rose(motor_stop))
        else $error("warning mode indication wrong");
    nom_revert_a: assert property (nom_change && !fw_load_wr // R8
        |=> fw_load == `FW_LOAD_DEFAULT && zero_load == `ZERO_LOAD_DEFAULT)
        else $error("load settings not restored");
    restart_limit_a: assert property (go |-> tries_used < max_tries ##1 restart_pulse) // R13
        else $error("restart beyond configured limit");
    restart_cond_a: assert property (restart_pulse |-> $past(restart_ok(pending, cond))) // R21
        else $error("restart before condition returned");
    trial_clear_a: assert property (trial_done && !go |=> tries_used == '0 && !trial_active) // R15
        else $error("trial expiry did not clear count");
    lock_hold_a: assert property (state == RS_LOCK && !fault_reset |=> state == RS_LOCK) // R23
        else $error("locked fault left without reset");
    ul_off_quiet_a: assert property ((ul_mode == `UL_MODE_OFF) // R1
        |=> ul_indication == `IND_NONE && !ul_warning)
        else $error("indication raised in off mode");
    fw_range_a: assert property (fw_load_wr && !nom_change // R6
        |=> fw_load >= `FW_LOAD_MIN && fw_load <= `FW_LOAD_MAX)
        else $error("field weakening load outside its range");
    zero_range_a: assert property (zero_load_wr && !nom_change // R7
        |=> zero_load >= `ZERO_LOAD_MIN && zero_load <= `ZERO_LOAD_MAX)
        else $error("zero frequency load outside its range");
    fly_capture_a: assert property (restart_pulse |-> restart_flying == $past(start_mode)) // R17
        else $error("restart method not captured");
    trial_open_a: assert property (go && !trial_active // R14
        |=> trial_active && trial_cnt == 16'h0)
        else $error("trial window did not open on first restart");
    ul_trip_lock_a: assert property (ul_trip && state == RS_IDLE |=> state == RS_LOCK) // R23
        else $error("underload trip did not lock");
    cause_enabled_a: assert property (state == RS_IDLE && fault_valid && !ul_trip && // R19
        (fault_kind & restart_en) == '0 |=> state == RS_LOCK)
        else $error("restart armed for a disabled cause");
    oc_restart_a: assert property (state == RS_IDLE && fault_valid && !ul_trip && // R19
        fault_kind.oc && restart_en.oc && tries_used < max_tries |=> state == RS_WAIT)
        else $error("enabled overcurrent fault not armed for restart");

endmodule // underload_restart

`default_nettype wire

/* tb/drive_core_model.sv */
// Drive control core model: live estimates and fault events
`timescale 1ns/1ps
`default_nettype none
module drive_core_model
    import underload_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic run_req,
    input wire logic [15:0] freq,
    input wire logic signed [15:0] torque,
    input wire logic [15:0] fw_point,
    input wire logic trip_req,
    input wire fault_kind_t trip_kind,
    input wire logic stop_cmd,
    output var drive_meas_t meas,
    output logic fault_valid,
    output var fault_kind_t fault_kind
);
    // ==========================================
    // Estimates: the motor is stopped while any fault holds the drive
    assign meas = {run_req & ~stop_cmd, freq, torque, fw_point};
    // ==========================================
    // Fault events: cause lines toggle between events so a stale code never looks valid
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            fault_valid <= 1'b0;
            fault_kind <= 5'h00;
        end else begin
            fault_valid <= trip_req;
            fault_kind <= trip_req ? trip_kind : ~fault_kind;
        end
    end
endmodule // drive_core_model
`default_nettype wire

/* tb/tb.sv */
// Self-checking bench for the underload and restart supervisor
`timescale 1ns/1ps
`default_nettype none
module tb;
    import underload_pkg::*;
    localparam int TK = 10;
    // ==========================================
    // Stimulus, outputs and counters
    logic sys_clk = 1'b0, rst_n = 1'b0, run_req = 1'b0, trip_req = 1'b0, start_mode = 1'b0;
    logic fw_load_wr = 1'b0, zero_load_wr = 1'b0, nom_current_wr = 1'b0, fault_reset = 1'b0;
    logic [1:0] ul_mode = 2'h0;
    logic [3:0] max_tries = 4'h2, ul_indication, tries_used;
    logic [15:0] ul_time = 16'h0005, trial_time = 16'h0014, fw_load_in = 16'h0000;
    logic [15:0] zero_load_in = 16'h0000, nom_current_in = 16'h0064, freq = 16'h0258;
    logic [15:0] fw_point = 16'h01f4, drive_rated_current = 16'h0064;
    logic [15:0] fw_load, zero_load, motor_nom_current, ul_count;
    logic signed [15:0] torque = 16'sh0064;
    fault_kind_t trip_kind = 5'h00, restart_en = 5'h1f, fault_kind;
    restart_cond_t cond = 33'h000000000;
    drive_meas_t meas;
    logic fault_valid, ul_warning, motor_stop, fault_active, restart_pulse, restart_flying;
    logic [31:0] lfsr = 32'he145;
    int failures = 0;
    int checks = 0;
    drive_core_model core (.sys_clk, .rst_n, .run_req, .freq, .torque, .fw_point, .trip_req,
        .trip_kind, .stop_cmd(fault_active), .meas, .fault_valid, .fault_kind);
    underload_restart #(.TICK_CYCLES(TK), .TRY_W(4)) u_underload_restart (.sys_clk, .rst_n,
        .meas, .ul_mode, .ul_time, .fw_load_wr, .fw_load_in, .zero_load_wr, .zero_load_in,
        .nom_current_wr, .nom_current_in, .drive_rated_current, .fault_valid, .fault_kind,
        .restart_en, .cond, .max_tries, .trial_time, .start_mode, .fault_reset, .fw_load,
        .zero_load, .motor_nom_current, .ul_count, .ul_warning, .ul_indication, .motor_stop,
        .fault_active, .restart_pulse, .restart_flying, .tries_used);
    always #25 sys_clk = ~sys_clk;
    // ==========================================
    // Helpers
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t %s %h exp %h", $time, what, seen, exp);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic bound(input int i, input int n);
        if (i >= n) begin
            failures++;
            $display("[FAIL] %0t timeout", $time);
            finish_test();
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic step1;
        @(posedge sys_clk);
        #1;
    endtask
    function automatic logic [31:0] rnd(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Squared curve below the weakening point, flat above it
    function automatic int thr(input int f, input int fwp, input int z, input int w);
        if (f >= fwp)
            return w;
        return z + (w - z) * f * f / (fwp * fwp);
    endfunction
    // Any TK consecutive edges hold exactly one tick; settle first for the torque path
    task automatic tick_step(input int delta);
        logic [15:0] c;
        cyc(3);
        #1;
        c = ul_count;
        cyc(TK);
        #1;
        check(ul_count, (delta < 0 && c == 16'h0000) ? c : c + 16'(delta), "count");
    endtask
    task automatic fault(input fault_kind_t k);
        @(posedge sys_clk);
        trip_kind <= k;
        trip_req <= 1'b1;
        @(posedge sys_clk);
        trip_req <= 1'b0;
    endtask
    task automatic exp_rs(input logic want, input int n);
        int i;
        logic seen;
        seen = 1'b0;
        for (i = 0; i < n && !seen; i++) begin
            step1();
            seen = (restart_pulse === 1'b1);
        end
        check(16'(seen), 16'(want), "restart");
    endtask
    task automatic clear_fault;
        @(posedge sys_clk);
        fault_reset <= 1'b1;
        @(posedge sys_clk);
        fault_reset <= 1'b0;
        cyc(2);
        #1;
        check(16'(fault_active), 16'h0000, "cleared");
    endtask
    // ==========================================
    // Main sequence
    initial begin
        int i;
        int f;
        int t;
        int sc;
        cyc(20);
        rst_n <= 1'b1;
        step1();
        check(fw_load, 16'h01f4, "fw rst");
        @(posedge sys_clk);
        fw_load_wr <= 1'b1;
        zero_load_wr <= 1'b1;
        fw_load_in <= 16'h0064;
        zero_load_in <= 16'h0032;
        @(posedge sys_clk);
        fw_load_in <= 16'h07d0;
        zero_load_in <= 16'h07d0;
        #1;
        check(fw_load, 16'h00c8, "fw lo");
        check(zero_load, 16'h0064, "zero lo");
        @(posedge sys_clk);
        fw_load_wr <= 1'b0;
        zero_load_wr <= 1'b0;
        nom_current_wr <= 1'b1;
        nom_current_in <= 16'h00c8;
        #1;
        check(fw_load, 16'h05dc, "fw hi");
        check(zero_load, 16'h05dc, "zero hi");
        @(posedge sys_clk);
        nom_current_in <= 16'h0064;
        #1;
        check(fw_load, 16'h01f4, "fw dflt");
        check(zero_load, 16'h0064, "zero dflt");
        @(posedge sys_clk);
        nom_current_wr <= 1'b0;
        ul_mode <= 2'h1;
        run_req <= 1'b1;
        for (i = 0; i < 300 && ul_warning !== 1'b1; i++)
            step1();
        bound(i, 300);
        check(ul_count, 16'h0015, "warn count");
        check(16'(ul_indication), 16'h0001, "warn code");
        check(16'(motor_stop), 16'h0000, "warn only");
        @(posedge sys_clk);
        torque <= 16'sh0384;
        tick_step(-1);
        step1();
        check(16'(ul_warning), 16'h0000, "warn off");
        @(posedge sys_clk);
        torque <= 16'sh0064;
        freq <= 16'h0031;
        tick_step(0);
        @(posedge sys_clk);
        freq <= 16'h0032;
        tick_step(1);
        @(posedge sys_clk);
        ul_mode <= 2'h0;
        cyc(2);
        #1;
        check(ul_count, 16'h0000, "mode off");
        @(posedge sys_clk);
        ul_mode <= 2'h1;
        tick_step(1);
        @(posedge sys_clk);
        run_req <= 1'b0;
        cyc(2);
        #1;
        check(ul_count, 16'h0000, "stopped");
        // ==========================================
        // Trip in fault mode
        @(posedge sys_clk);
        ul_mode <= 2'h2;
        run_req <= 1'b1;
        for (i = 0; i < 300 && motor_stop !== 1'b1; i++)
            step1();
        bound(i, 300);
        check(ul_count, 16'h0015, "trip count");
        check(16'(ul_indication), 16'h0001, "trip code");
        check(16'(fault_active), 16'h0001, "trip");
        check(16'(ul_warning), 16'h0000, "no warn");
        @(posedge sys_clk);
        ul_mode <= 2'h0;
        clear_fault();
        // ==========================================
        // Random points on the curve, boundaries first
        @(posedge sys_clk);
        ul_mode <= 2'h1;
        ul_time <= 16'h1770;
        fw_point <= 16'h03e8;
        torque <= 16'sh0000;
        cyc(5 * TK);
        for (i = 0; i < 40; i++) begin
            lfsr = rnd(lfsr);
            f = (i == 0) ? 1000 : (i == 1) ? 50 : 50 + int'(lfsr[10:0]);
            sc = lfsr[11] ? 200 : 100;
            t = thr(f, 1000, 100, 500) + (lfsr[12] ? -10 : 10);
            @(posedge sys_clk);
            freq <= 16'(f);
            drive_rated_current <= 16'(sc);
            torque <= 16'(t * 100 / sc);
            tick_step(lfsr[12] ? 1 : -1);
        end
        // ==========================================
        // Restart: each disabled cause locks even with its condition met
        @(posedge sys_clk);
        ul_mode <= 2'h0;
        torque <= 16'sh0384;
        cond <= {1'b1, 16'h0191, 16'sh0014};
        for (i = 0; i < 5; i++) begin
            @(posedge sys_clk);
            restart_en <= fault_kind_t'(5'h1f ^ (5'h01 << i));
            fault(fault_kind_t'(5'h01 << i));
            exp_rs(1'b0, 20);
            clear_fault();
        end
        @(posedge sys_clk);
        restart_en <= 5'h1f;
        cond <= {1'b0, 16'h0190, 16'shfff5};
        fault(5'h10);
        exp_rs(1'b0, 300);
        @(posedge sys_clk);
        cond.dc_ok <= 1'b1;
        exp_rs(1'b1, 5);
        check(16'(restart_flying), 16'h0000, "ramp");
        cyc(100);
        #1;
        check(16'(tries_used), 16'h0001, "trial open");
        @(posedge sys_clk);
        start_mode <= 1'b1;
        fault(5'h02);
        exp_rs(1'b0, 20);
        @(posedge sys_clk);
        cond.ref_current <= 16'h0191;
        exp_rs(1'b1, 5);
        check(16'(tries_used), 16'h0002, "two tries");
        check(16'(restart_flying), 16'h0001, "flying");
        fault(5'h04);
        exp_rs(1'b0, 30);
        clear_fault();
        for (i = 0; i < 400 && tries_used !== 4'h0; i++)
            step1();
        bound(i, 400);
        check(16'(tries_used), 16'h0000, "trial clear");
        fault(5'h01);
        exp_rs(1'b0, 20);
        @(posedge sys_clk);
        cond.heatsink_temp <= 16'sh004c;
        exp_rs(1'b0, 20);
        @(posedge sys_clk);
        cond.heatsink_temp <= 16'sh004b;
        exp_rs(1'b1, 5);
        check(16'(tries_used), 16'h0001, "fresh count");
        @(posedge sys_clk);
        cond.heatsink_temp <= 16'shfff6;
        fault(5'h01);
        exp_rs(1'b1, 5);
        @(posedge sys_clk);
        max_tries <= 4'h3;
        fault(5'h04);
        exp_rs(1'b1, 5);
        check(16'(tries_used), 16'h0003, "third try");
        finish_test();
    end
endmodule // tb
`default_nettype wire
